// >>> pfr_frame_receiver.sv
// Purpose: Two-channel receive path: threshold, Manchester decode,
//          frame parse, check and per-slot receive entries.
// Assumes: Current samples are synchronous to mclk.
// Notes:   Registers are a classic Wishbone slave with one wait state.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module pfr_frame_receiver (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic                           wb_ack_o,
    output logic [31:0]                    wb_dat_o,
    input  wire logic [pfr_pkg::CUR_W-1:0] sensor_line_0_current,
    input  wire logic [pfr_pkg::CUR_W-1:0] sensor_line_1_current,
    input  wire logic                      sync_pulse_0,
    input  wire logic                      sync_pulse_1
);
    import pfr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State and helpers.
    ////////////////////////////////////////////////////////////////////
    pfr_state_s state_q;          // All registered state.
    pfr_state_s state_d;          // Next state.
    logic [N_CH-1:0] com_v;       // Entry written this cycle.
    logic [N_CH-1:0] com_err;     // Written entry is a decode error.
    logic [CUR_W-1:0] cur [N_CH]; // Samples per channel.
    logic [N_CH-1:0] sync;        // Sync pulse per channel.

    assign cur[0] = sensor_line_0_current;
    assign cur[1] = sensor_line_1_current;
    assign sync = {sync_pulse_1, sync_pulse_0};
    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = state_q.rdat;

    // First order tracking step; the shift sets the time constant.
    function automatic logic [CUR_W-1:0] trk(
        input logic [CUR_W-1:0] c,
        input logic [CUR_W-1:0] t,
        input int sh
    );
        logic signed [CUR_W+1:0] d;
        d = $signed({2'b00, t}) - $signed({2'b00, c});
        // Small rising gaps would shift to zero; step by one count instead.
        d = (d > 12'sh000 && (d >>> sh) == 12'sh000) ? 12'sh001 : d >>> sh;
        return c + d[CUR_W-1:0];
    endfunction

    // One serial step of the x^3+x+1 check register.
    function automatic logic [2:0] crc_step(
        input logic [2:0] c,
        input logic b
    );
        logic fb;
        fb = c[2] ^ b;
        return {c[1], c[0] ^ fb, fb}; // RULE24
    endfunction

    // Byte lane merge for partial writes.
    function automatic logic [31:0] wmerge(
        input logic [31:0] o,
        input logic [31:0] w,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Length field clamped to 8 to 28; the legal data region range is 10 to 28.
    function automatic logic [4:0] clamp_len(input logic [4:0] l);
        if (l < LEN_MIN) begin
            return LEN_MIN;
        end
        if (l > LEN_MAX) begin
            return LEN_MAX;
        end
        return l; // RULE21
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state logic: bus first, then the channel decoders.
    ////////////////////////////////////////////////////////////////////
    // The bus read clear is applied before the decoders so that a frame
    // landing in the same cycle overwrites the clear and is not lost.
    always_comb begin
        logic req, csel, edg, b, ok, merr, fin;
        logic [31:0] rmux;
        logic [31:0] wv;
        logic [2:0] idx;
        logic [CUR_W:0] thr;
        logic [CUR_W-1:0] diff;
        logic [8:0] nom, lo, hi;
        logic [4:0] len, tot;
        logic [ENT_W-1:0] val;
        pfr_chan_s c, n;
        rmux = 32'h0;
        wv = 32'h0;
        idx = wb_adr_i[4:2];
        req = wb_cyc_i && wb_stb_i && !state_q.ack;
        thr = '0;
        diff = '0;
        nom = 9'h0;
        lo = 9'h0;
        hi = 9'h0;
        len = 5'h0;
        tot = 5'h0;
        csel = 1'b0;
        edg = 1'b0;
        b = 1'b0;
        ok = 1'b0;
        merr = 1'b0;
        fin = 1'b0;
        val = '0;
        c = '0;
        n = '0;
        com_v = '0;
        com_err = '0;
        state_d = state_q;
        state_d.ack = req;
        // Read multiplexer; unmapped addresses read as zero.
        if (wb_adr_i == A_GCFG) begin
            rmux[0] = state_q.chk_on;
        end else if (wb_adr_i == A_TUNE) begin
            rmux[1:0] = state_q.rate;
            rmux[2] = state_q.measure;
            rmux[5:4] = state_q.dyn;
            rmux[9:8] = state_q.hold_dis;
        end else if (wb_adr_i == A_DELTA) begin
            rmux[9:0] = state_q.delta[0];
            rmux[25:16] = state_q.delta[1];
        end else if (wb_adr_i == A_STAT) begin
            for (int k = 0; k < N_CH; k++) begin
                rmux[k*8 +: 2] = state_q.ch[k].st;
                rmux[k*8+2 +: 3] = state_q.ch[k].slot;
            end
        end else if (wb_adr_i == A_IQ) begin
            rmux[9:0] = state_q.ch[0].iq;
            rmux[25:16] = state_q.ch[1].iq;
        end else if (idx < 3'(N_SLOT) && wb_adr_i[1:0] == 2'h0) begin
            if (wb_adr_i[7:5] == A_FCFG_HI) begin
                rmux[4:0] = state_q.flen[0][idx];
                rmux[5] = state_q.fcrc[0][idx];
                rmux[20:16] = state_q.flen[1][idx];
                rmux[21] = state_q.fcrc[1][idx];
            end else if (wb_adr_i[7:5] == A_BUF0_HI) begin
                rmux[ENT_W-1:0] = state_q.ch[0].ent[idx];
            end else if (wb_adr_i[7:5] == A_BUF1_HI) begin
                rmux[ENT_W-1:0] = state_q.ch[1].ent[idx];
            end
        end
        wv = wmerge(rmux, wb_dat_i, wb_sel_i);
        // A taken request; reads of entries empty them.
        if (req && wb_we_i) begin
            if (wb_adr_i == A_GCFG) begin
                state_d.chk_on = wv[0]; // RULE17
            end else if (wb_adr_i == A_TUNE) begin
                state_d.rate = wv[1:0];
                state_d.measure = wv[2];
                state_d.dyn = wv[5:4];
                state_d.hold_dis = wv[9:8];
            end else if (wb_adr_i == A_DELTA) begin
                state_d.delta[0] = wv[9:0];
                state_d.delta[1] = wv[25:16];
            end else if (wb_adr_i[7:5] == A_FCFG_HI && idx < 3'(N_SLOT)
                         && wb_adr_i[1:0] == 2'h0) begin
                state_d.flen[0][idx] = clamp_len(wv[4:0]); // RULE14
                state_d.fcrc[0][idx] = wv[5];
                state_d.flen[1][idx] = clamp_len(wv[20:16]);
                state_d.fcrc[1][idx] = wv[21];
            end
        end else if (req) begin
            state_d.rdat = rmux;
            if (idx < 3'(N_SLOT) && wb_adr_i[1:0] == 2'h0) begin
                if (wb_adr_i[7:5] == A_BUF0_HI) begin
                    state_d.ch[0].ent[idx] = ENT_W'(CODE_EMPTY);
                end else if (wb_adr_i[7:5] == A_BUF1_HI) begin
                    state_d.ch[1].ent[idx] = ENT_W'(CODE_EMPTY);
                end
            end
        end
        // Each channel runs its own decoder from the common clock.
        for (int k = 0; k < N_CH; k++) begin // RULE23 RULE5
            c = state_q.ch[k];
            n = state_d.ch[k];
            merr = 1'b0;
            fin = 1'b0;
            n.filt = trk(c.filt, cur[k], FILT_SHIFT);
            // A one count per cycle tracking step keeps a short supply cut
            // from dragging the quiescent level far enough to miss frames.
            if (c.st == DEC_IDLE || state_q.hold_dis[k]) begin // RULE1
                n.iq = trk(c.iq, c.filt, IQ_SHIFT); // RULE6
            end
            // Amplitude follows the frame peaks and decays slowly.
            diff = (c.filt > c.iq) ? c.filt - c.iq : '0;
            if (c.st != DEC_IDLE && diff > c.amp) begin
                n.amp = diff; // RULE3
            end else begin
                n.amp = c.amp - (c.amp >> AMP_SHIFT);
            end
            if (n.amp < state_q.delta[k]) begin
                n.amp = state_q.delta[k];
            end
            if (state_q.dyn[k]) begin
                thr = {1'b0, c.iq} + {2'b00, c.amp[CUR_W-1:1]}; // RULE3
            end else begin
                thr = {1'b0, c.iq} + {1'b0, state_q.delta[k]}; // RULE2
            end
            n.lvl = {1'b0, c.filt} > thr;
            n.lvl_p = c.lvl;
            edg = c.lvl != c.lvl_p;
            n.cnt = (c.cnt == 9'h1FF) ? c.cnt : c.cnt + 9'h1;
            // Nominal period from the selected rate.
            unique case (state_q.rate) // RULE7
                RATE_SLOW: nom = PER_SLOW;
                RATE_FAST: nom = PER_FAST;
                default: nom = PER_STD;
            endcase
            len = state_q.flen[k][c.slot];
            csel = state_q.fcrc[k][c.slot];
            tot = len + (csel ? 5'h3 : 5'h1); // RULE19
            lo = (c.st == DEC_DATA) ? c.per : nom;
            hi = 9'((17'(lo) * (17'h64 + 17'(TOL_PCT))) / 17'h64);
            lo = 9'((17'(lo) * (17'h64 - 17'(TOL_PCT))) / 17'h64);
            unique case (c.st)
                DEC_IDLE: begin
                    // A rising mid-bit edge opens the first start bit.
                    if (edg && c.lvl) begin // RULE8
                        n.st = DEC_START;
                        n.cnt = 9'h0;
                        n.bnd = 1'b0;
                    end
                end
                DEC_START: begin
                    if (edg && !c.lvl && !c.bnd && c.cnt < lo) begin
                        n.bnd = 1'b1;
                    end else if (edg && c.lvl && c.cnt >= lo
                                 && c.cnt <= hi) begin
                        // Second zero start bit; lock the bit timing.
                        n.st = DEC_DATA; // RULE8
                        n.per = state_q.measure ? c.cnt : nom; // RULE9
                        n.cnt = 9'h0;
                        n.bnd = 1'b0;
                        n.nbit = 5'h0;
                        n.data = '0;
                        n.chk = '0;
                        n.crc = CRC_SEED; // RULE24
                        n.par = 1'b0;
                    end else if (edg || c.cnt > hi) begin
                        merr = 1'b1; // RULE11
                    end
                end
                DEC_DATA: begin
                    if (edg && c.cnt < lo) begin
                        // One bit-boundary edge may sit between mid edges.
                        if (c.bnd) begin
                            merr = 1'b1; // RULE10
                        end
                        n.bnd = 1'b1;
                    end else if (edg) begin
                        b = !c.lvl;
                        if (c.nbit >= tot) begin
                            merr = 1'b1; // RULE11
                        end else if (c.nbit < len) begin
                            n.data[c.nbit] = b; // RULE20
                            n.crc = crc_step(c.crc, b);
                            n.par = c.par ^ b;
                        end else begin
                            n.chk[2'(c.nbit - len)] = b;
                        end
                        n.nbit = c.nbit + 5'h1;
                        n.cnt = 9'h0;
                        n.bnd = 1'b0;
                    end else if (c.cnt > hi) begin
                        // Silence ends the frame; length and stop level.
                        if (c.nbit == tot && !c.lvl) begin
                            fin = 1'b1; // RULE18
                            n.st = DEC_IDLE;
                        end else begin
                            merr = 1'b1; // RULE11 RULE10
                        end
                    end
                end
                DEC_QUIET: begin
                    // Wait out the rest of a broken frame.
                    if (edg) begin
                        n.cnt = 9'h0;
                    end else if (c.cnt > hi) begin
                        n.st = DEC_IDLE;
                    end
                end
            endcase
            if (state_q.chk_on) begin
                ok = csel ? (c.crc == {c.chk[0], c.chk[1], c.chk[2]})
                          : (c.par == c.chk[0]);
                val = ok ? {3'b000, c.data}
                         : ENT_W'(CODE_PARITY); // RULE16
            end else begin
                val = {c.chk, c.data}; // RULE15 RULE22
            end
            if (merr) begin
                val = ENT_W'(CODE_MANCH); // RULE12
                n.st = DEC_QUIET;
                n.cnt = 9'h0;
            end
            if (merr || fin) begin
                n.ent[c.slot] = val; // RULE13
                n.slot = (c.slot == 3'(N_SLOT - 1)) ? 3'h0
                                                   : c.slot + 3'h1;
                com_v[k] = 1'b1;
                com_err[k] = merr;
            end
            if (sync[k]) begin
                n.slot = 3'h0;
            end
            state_d.ch[k] = n;
        end
        // Synchronous reset values.
        if (!rst_n) begin
            state_d = '0;
            state_d.rate = RATE_STD;
            for (int k = 0; k < N_CH; k++) begin
                state_d.delta[k] = DELTA_RST;
                state_d.ch[k].st = DEC_IDLE;
                state_d.ch[k].amp = DELTA_RST;
                state_d.ch[k].per = PER_STD;
                state_d.ch[k].crc = CRC_SEED;
                for (int s = 0; s < N_SLOT; s++) begin
                    state_d.flen[k][s] = LEN_RST;
                    state_d.ch[k].ent[s] = ENT_W'(CODE_EMPTY);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////
    // Reset is folded into the next state, so this is a plain register.
    always_ff @(posedge mclk) begin
        state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on channel 0 and the bus.
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_iq_frozen: assert property ( // RULE1
        (state_q.ch[0].st != DEC_IDLE && !state_q.hold_dis[0])
        |=> $stable(state_q.ch[0].iq))
        else $error("quiescent level moved inside a frame");
    a_fixed_level: assert property ( // RULE2
        !state_q.dyn[0] |=> (state_q.ch[0].lvl ==
        ({1'b0, $past(state_q.ch[0].filt)} >
         {1'b0, $past(state_q.ch[0].iq)} + {1'b0, $past(state_q.delta[0])})))
        else $error("fixed threshold level wrong");
    a_start_rise: assert property ( // RULE8
        (state_q.ch[0].st == DEC_IDLE) ##1 (state_q.ch[0].st == DEC_START)
        |-> $past(state_q.ch[0].lvl) && !$past(state_q.ch[0].lvl_p))
        else $error("frame opened without rising edge");
    a_cnt_window: assert property ( // RULE10
        state_q.ch[0].st == DEC_DATA |-> 10'(state_q.ch[0].cnt) <=
        10'(state_q.ch[0].per) + 10'(state_q.ch[0].per / 9'd5) + 10'd1)
        else $error("bit window overran tolerance");
    a_manch_code: assert property ( // RULE12
        com_err[0] && !sync[0] |=>
        state_q.ch[0].ent[$past(state_q.ch[0].slot)] == ENT_W'(CODE_MANCH))
        else $error("error code not stored");
    a_slot_range: assert property ( // RULE13
        state_q.ch[0].slot < 3'(N_SLOT))
        else $error("slot index out of range");
    a_len_range: assert property ( // RULE19
        state_q.flen[0][0] >= LEN_MIN && state_q.flen[0][0] <= LEN_MAX)
        else $error("frame length outside range");
    a_read_clear: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h40
         && !(com_v[0] && state_q.ch[0].slot == 3'h0))
        |=> state_q.ch[0].ent[0] == ENT_W'(CODE_EMPTY))
        else $error("read did not empty entry");
endmodule

// >>> pfr_pkg.sv
// Purpose: Shared constants and state types of the two-channel sensor
//          frame receiver.
// Assumes: One 20 MHz clock; registers reached over classic Wishbone.
// Notes:   Summary of the block behaviour follows.
// Summary of operation
// RULE1 - Quiescent tracking continuous or frozen during frames.
// RULE2 - Fixed mode: level above quiescent plus delta.
// RULE3 - Dynamic mode: threshold follows received modulation amplitude.
// RULE4 - Software never mixes dynamic threshold and low power.
// RULE5 - Each channel tracks its own quiescent level.
// RULE6 - Ten microsecond supply cuts lose one frame.
// RULE7 - Slow, standard and fast bit rates supported.
// RULE8 - Two zero start bits open and synchronise frame.
// RULE9 - Check bits against measured start period or nominal.
// RULE10 - Over twenty percent timing deviation is Manchester error.
// RULE11 - Start, length, stop and edge faults raise error.
// RULE12 - Manchester error stores its error code instead.
// RULE13 - Per channel six entries of 28+3 bits.
// RULE14 - Per frame slot length and CRC/parity select.
// RULE15 - Checking off: forward data and check bits.
// RULE16 - Checking on: store payload or parity error code.
// RULE17 - One global checking select for all sensors.
// RULE18 - Store frame only after all bits arrived.
// RULE19 - Frame is start bits, data, parity or CRC.
// RULE20 - Data LSB first; check covers whole data region.
// RULE21 - Data length settable from 10 to 28; the code clamps to 8 to 28.
// RULE22 - Data region holds payloads, status, control, messaging.
// RULE23 - One independent decoder per channel, common clock.
// RULE24 - CRC uses standard polynomial and seed.
package pfr_pkg;
    // Clock and nominal bit rates, as printed.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned RATE_SLOW_BPS = 83_300;
    localparam int unsigned RATE_STD_BPS = 125_000;
    localparam int unsigned RATE_FAST_BPS = 189_000;
    // Nominal bit periods in clock cycles.
    localparam logic [8:0] PER_SLOW = 9'(CLK_HZ / RATE_SLOW_BPS);
    localparam logic [8:0] PER_STD = 9'(CLK_HZ / RATE_STD_BPS);
    localparam logic [8:0] PER_FAST = 9'(CLK_HZ / RATE_FAST_BPS);
    // Timing tolerance in percent.
    localparam int unsigned TOL_PCT = 20;
    // Rate select codes.
    localparam logic [1:0] RATE_SLOW = 2'h0;
    localparam logic [1:0] RATE_STD = 2'h1;
    localparam logic [1:0] RATE_FAST = 2'h2;
    // Sample width and filter shifts.
    localparam int CUR_W = 10;
    localparam int FILT_SHIFT = 2;
    localparam int IQ_SHIFT = 10;
    localparam int AMP_SHIFT = 8;
    // Frame geometry.
    localparam int N_CH = 2;
    localparam int N_SLOT = 6;
    localparam int DATA_W = 28;
    localparam int CHK_W = 3;
    localparam int ENT_W = DATA_W + CHK_W;
    localparam logic [4:0] LEN_MIN = 5'h08;
    localparam logic [4:0] LEN_MAX = 5'h1C;
    localparam logic [4:0] LEN_RST = 5'h0A;
    localparam logic [CUR_W-1:0] DELTA_RST = 10'h040;
    // Error codes stored in the low bits of an entry.
    localparam logic [9:0] CODE_MANCH = 10'h1FC;
    localparam logic [9:0] CODE_PARITY = 10'h1F8;
    localparam logic [9:0] CODE_EMPTY = 10'h1F0;
    // Check polynomial x^3+x+1 and seed.
    localparam logic [2:0] CRC_SEED = 3'h7;
    // Register byte addresses.
    localparam logic [7:0] A_GCFG = 8'h00;
    localparam logic [7:0] A_TUNE = 8'h04;
    localparam logic [7:0] A_DELTA = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_IQ = 8'h10;
    localparam logic [2:0] A_FCFG_HI = 3'h1;
    localparam logic [2:0] A_BUF0_HI = 3'h2;
    localparam logic [2:0] A_BUF1_HI = 3'h3;
    // Decoder states.
    typedef enum logic [1:0] {
        DEC_IDLE, DEC_START, DEC_DATA, DEC_QUIET
    } pfr_dec_e;
    // Per channel state.
    typedef struct packed {
        pfr_dec_e st;
        logic [CUR_W-1:0] filt;
        logic [CUR_W-1:0] iq;
        logic [CUR_W-1:0] amp;
        logic lvl;
        logic lvl_p;
        logic [8:0] cnt;
        logic [8:0] per;
        logic bnd;
        logic [4:0] nbit;
        logic [DATA_W-1:0] data;
        logic [CHK_W-1:0] chk;
        logic [2:0] crc;
        logic par;
        logic [2:0] slot;
        logic [N_SLOT-1:0][ENT_W-1:0] ent;
    } pfr_chan_s;
    // Whole block state.
    typedef struct packed {
        logic chk_on;
        logic [1:0] rate;
        logic measure;
        logic [N_CH-1:0] dyn;
        logic [N_CH-1:0] hold_dis;
        logic [N_CH-1:0][CUR_W-1:0] delta;
        logic [N_CH-1:0][N_SLOT-1:0][4:0] flen;
        logic [N_CH-1:0][N_SLOT-1:0] fcrc;
        logic ack;
        logic [31:0] rdat;
        pfr_chan_s [N_CH-1:0] ch;
    } pfr_state_s;
endpackage

// >>> pfr_sensor_model.sv
// Purpose: Sensor on the line side, modulating current with Manchester bits.
// Assumes: One bit lasts per cycles of mclk; the line idles at quiescent.
// Notes:   Bits leave index 0 first; the caller places the start bits there.
`timescale 1ns/1ns
module pfr_sensor_model (
    input  wire logic       mclk,
    output logic      [9:0] cur
);
    // Quiescent and modulated levels, far apart compared with the delta.
    localparam logic [9:0] LO = 10'h080;
    localparam logic [9:0] HI = 10'h180;
    initial cur = LO;
    // A zero rises at mid bit and a one falls at mid bit.
    task automatic send(input logic [31:0] b, input int nb, input int per);
        for (int i = 0; i < nb; i++) begin
            repeat (per / 2) @(posedge mclk) cur <= b[i] ? HI : LO;
            repeat (per - per / 2) @(posedge mclk) cur <= b[i] ? LO : HI;
        end
        // A long quiet lets the receiver close the frame.
        repeat (3 * per) @(posedge mclk) cur <= LO;
    endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the two-channel frame receiver.
// Assumes: Standard rate, then fast; ten data bits in every slot.
// Notes:   Both channels see the same sensor, so their entries must agree.
`timescale 1ns/1ns
module tb_top;
    import pfr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic        ack;
    logic [31:0] dat;
    logic        sync = 1'b0;
    logic [9:0]  cur;
    logic [9:0]  d;
    int          seed;
    int          err_total = 0;
    int          total_checks = 0;
    always #25 mclk = ~mclk;
    pfr_sensor_model SEN (.mclk(mclk), .cur(cur));
    pfr_frame_receiver DUT (.mclk(mclk), .rst_n(rst_n),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dat),
        .sensor_line_0_current(cur), .sensor_line_1_current(cur),
        .sync_pulse_0(sync), .sync_pulse_1(sync));
    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Compares a read word with its expected value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; the wait is bounded so a dead slave ends the run.
    // Ack is looked at on the falling edge, where it has settled, and the
    // request is released on the rising edge that samples it high.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do begin
            @(negedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat;
        @(posedge mclk);
        req <= 1'b0;
        if (n >= 20) begin
            err_total++;
            $display("mismatch at %0t: no ack", $time);
            print_verdict();
        end
    endtask
    // Pass mode entry: parity bit above the data, which sits LSB first.
    function automatic logic [31:0] pass_ent(input logic [9:0] v);
        return {3'b000, ^v, 18'h0, v};
    endfunction
    // Check bits in sending order: x^3+x+1, seed 111, data LSB first.
    function automatic logic [2:0] crc_bits(input logic [9:0] v);
        logic [2:0] c;
        c = 3'h7;
        for (int i = 0; i < 10; i++) begin
            c = {c[1], c[0] ^ c[2] ^ v[i], c[2] ^ v[i]};
        end
        return {c[0], c[1], c[2]};
    endfunction
    // Two zero start bits, ten data bits, then the check bit.
    task automatic frame(input logic [9:0] v, input logic p, input int nb);
        SEN.send({19'h0, p, v, 2'b00}, nb, int'(PER_STD));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: pass mode first, then on-device checking.
    initial begin
        seed = 9;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // The slow quiescent tracker needs time to reach the idle level.
        repeat (10000) @(posedge mclk);
        sync <= 1'b1;
        @(posedge mclk);
        sync <= 1'b0;
        d = 10'($random(seed));
        frame(d, ^d, 13);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, pass_ent(d));
        wb(1'b0, 8'h60, 32'h0);
        chk(rd, pass_ent(d));
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h1F0);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        // Low power mode is never used, so dynamic threshold never meets it.
        wb(1'b1, 8'h00, 32'h1);
        d = 10'h3FF;
        frame(d, 1'b0, 13);
        wb(1'b0, 8'h44, 32'h0);
        chk(rd, {22'h0, d});
        wb(1'b0, 8'h64, 32'h0);
        chk(rd, {22'h0, d});
        d = 10'($random(seed));
        frame(d, ~^d, 13);
        wb(1'b0, 8'h48, 32'h0);
        chk(rd, 32'h1F8);
        frame(d, ^d, 12);
        wb(1'b0, 8'h4C, 32'h0);
        chk(rd, 32'h1FC);
        // Slot four carries a three bit CRC on both channels.
        wb(1'b1, 8'h30, 32'h002A002A);
        d = 10'($random(seed));
        SEN.send({17'h0, crc_bits(d), d, 2'b00}, 15, int'(PER_STD));
        wb(1'b0, 8'h50, 32'h0);
        chk(rd, {22'h0, d});
        wb(1'b0, 8'h70, 32'h0);
        chk(rd, {22'h0, d});
        // Fast rate, measured start period; channel 0 uses the dynamic
        // threshold and channel 1 tracks the quiescent level throughout.
        wb(1'b1, 8'h04, 32'h00000216);
        d = 10'($random(seed));
        SEN.send({19'h0, ^d, d, 2'b00}, 13, int'(PER_FAST));
        wb(1'b0, 8'h54, 32'h0);
        chk(rd, {22'h0, d});
        wb(1'b0, 8'h74, 32'h0);
        chk(rd, {22'h0, d});
        print_verdict();
    end
endmodule
